// ===== core/chgsup_top.v
/*
  Charger safety and status logic: timer decode and supervision, open-drain
  status indicator, thermistor suspend and temperature interrupts.
  Assumes synchronous comparator inputs and a single-cycle register port.
*/
`include "chgsup_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module chgsup_top #(
  parameter [31:0] TICK_CYCLES = `CHGSUP_TICK_CYCLES  // Cycles per timer second
) (
  input  wire        mclk,               // Core clock, 100 MHz
  input  wire        rst_n,              // Async reset, active low
  input  wire [3:0]  reg_addr,           // Register index
  input  wire [7:0]  reg_wdata,          // Write data
  input  wire        reg_wr,             // Write strobe
  input  wire        reg_rd,             // Read strobe
  output reg  [7:0]  reg_rdata_ff,       // Read data, cycle after strobe
  input  wire [2:0]  charger_state,      // State of charge state machine
  input  wire        new_cycle,          // Pulse: new charge cycle begins
  input  wire        precond_done,       // Battery above precondition threshold
  input  wire [7:0]  charge_cur_ratio,   // Thermal current share, 255 = full
  input  wire        hot_threshold,      // Thermistor below hot level
  input  wire        cold_threshold,     // Thermistor above cold level
  output reg         charge_suspend_ff,  // Hold charging off
  output reg         precond_fault_ff,   // Request time-out fault
  output reg         total_expired_ff,   // Total-charge timeout reached
  output reg         charge_indicator_n_o,  // Open-drain output level, always 0
  output reg         charge_indicator_n_oe, // High while sinking
  output reg         irq_ff              // Level interrupt
);
  // ----------------------------------------------------------------------
  // Timeout decode
  // ----------------------------------------------------------------------
  // Products are formed at full width and cut on purpose; the longest
  // setting still fits the 16-bit second counter of the timers.
  function [15:0] pre_secs;
    input [1:0]  code;
    reg   [31:0] secs;
    begin
      case (code)
        2'b00:   secs = 60 * `CHGSUP_PRE_MIN_0;
        2'b01:   secs = 60 * `CHGSUP_PRE_MIN_1;
        2'b10:   secs = 60 * `CHGSUP_PRE_MIN_2;
        default: secs = 32'h0000_0000;
      endcase
      pre_secs = secs[15:0];
    end
  endfunction

  function [15:0] tot_secs;
    input [1:0]  code;
    reg   [31:0] secs;
    begin
      case (code)
        2'b00:   secs = 3600 * `CHGSUP_TOT_HR_0;
        2'b01:   secs = 3600 * `CHGSUP_TOT_HR_1;
        2'b10:   secs = 3600 * `CHGSUP_TOT_HR_2;
        default: secs = 32'h0000_0000;
      endcase
      tot_secs = secs[15:0];
    end
  endfunction

  function is_active;
    input [2:0] st;
    begin
      is_active = (st == `CHGSUP_ST_PRECOND) || (st == `CHGSUP_ST_FAST) ||
                  (st == `CHGSUP_ST_TOPOFF);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  localparam [3:0] CTRL_RST = `CHGSUP_CTRL_RST;

  reg [1:0]  precond_timeout_sel_ff;
  reg [1:0]  total_timeout_sel_ff;
  reg        temp_exit_irq_en_ff;
  reg        temp_enter_irq_en_ff;
  reg        temp_master_en_ff;
  reg        temp_irq_pending_ff;
  reg [3:0]  ev_stat_ff;
  reg [3:0]  ev_mask_ff;
  reg        temp_in_range_ff;
  reg [31:0] tick_cnt_ff;
  reg        tick_ff;
  reg        pre_exp_d_ff;
  reg        tot_exp_d_ff;

  wire       pre_exp;
  wire       tot_exp;
  wire       in_window = hot_threshold && cold_threshold;
  wire       wr_ctrl   = reg_wr && reg_addr == `CHGSUP_REG_CTRL;
  wire       wr_temp   = reg_wr && reg_addr == `CHGSUP_REG_TEMP;
  wire       wr_stat   = reg_wr && reg_addr == `CHGSUP_REG_IRQ_STAT;
  wire       wr_mask   = reg_wr && reg_addr == `CHGSUP_REG_IRQ_MASK;
  wire       rd_temp   = reg_rd && reg_addr == `CHGSUP_REG_TEMP;
  wire       ev_exit   = temp_in_range_ff && !in_window;
  wire       ev_enter  = !temp_in_range_ff && in_window;
  wire       temp_irq  = temp_master_en_ff &&
                         ((ev_exit && temp_exit_irq_en_ff) ||
                          (ev_enter && temp_enter_irq_en_ff));
  wire [3:0] ev_set    = {tot_exp && !tot_exp_d_ff, pre_exp && !pre_exp_d_ff,
                          ev_enter, ev_exit};
  wire [3:0] nxt_ev_stat = (ev_stat_ff & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | ev_set;

  // ----------------------------------------------------------------------
  // Time base: one tick per timer second
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff >= TICK_CYCLES - 32'h0000_0001) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Safety timers
  // ----------------------------------------------------------------------
  chgsup_timer u_pre (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .restart    (new_cycle),
    .run        (charger_state == `CHGSUP_ST_PRECOND && !precond_done),
    .tick       (tick_ff),
    .cur_ratio  (charge_cur_ratio),
    .limit_s    (pre_secs(precond_timeout_sel_ff)),
    .expired_ff (pre_exp)
  );

  chgsup_timer u_tot (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .restart    (new_cycle),
    .run        (is_active(charger_state)),
    .tick       (tick_ff),
    .cur_ratio  (charge_cur_ratio),
    .limit_s    (tot_secs(total_timeout_sel_ff)),
    .expired_ff (tot_exp)
  );

  // ----------------------------------------------------------------------
  // Control registers and writes
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      precond_timeout_sel_ff <= CTRL_RST[1:0];
      total_timeout_sel_ff   <= CTRL_RST[3:2];
      temp_exit_irq_en_ff    <= 1'b0;
      temp_enter_irq_en_ff   <= 1'b0;
      temp_master_en_ff      <= 1'b0;
      ev_mask_ff             <= `CHGSUP_MASK_RST;
      ev_stat_ff             <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        precond_timeout_sel_ff <= reg_wdata[`CHGSUP_CTRL_PRE_LSB +: 2];
        total_timeout_sel_ff   <= reg_wdata[`CHGSUP_CTRL_TOT_LSB +: 2];
      end
      if (wr_temp) begin
        temp_exit_irq_en_ff  <= reg_wdata[`CHGSUP_TEMP_EXIT_EN];
        temp_enter_irq_en_ff <= reg_wdata[`CHGSUP_TEMP_ENTER_EN];
        temp_master_en_ff    <= reg_wdata[`CHGSUP_TEMP_MASTER_EN];
      end
      if (wr_mask)
        ev_mask_ff <= reg_wdata[3:0];
      // Set wins over a write-one-to-clear in the same cycle
      ev_stat_ff <= nxt_ev_stat;
    end
  end

  // ----------------------------------------------------------------------
  // Temperature supervision
  // ----------------------------------------------------------------------
  // Range flag starts as in-range so a cold start outside the window still
  // raises an exit event on the first cycle.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp_in_range_ff    <= 1'b1;
      temp_irq_pending_ff <= 1'b0;
      charge_suspend_ff   <= 1'b0;
    end else begin
      temp_in_range_ff  <= in_window;
      charge_suspend_ff <= !in_window;
      if (temp_irq)
        temp_irq_pending_ff <= 1'b1;
      else if (rd_temp)
        temp_irq_pending_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Timer faults, indicator, interrupt
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_exp_d_ff          <= 1'b0;
      tot_exp_d_ff          <= 1'b0;
      precond_fault_ff      <= 1'b0;
      total_expired_ff      <= 1'b0;
      charge_indicator_n_o  <= 1'b0;
      charge_indicator_n_oe <= 1'b0;
      irq_ff                <= 1'b0;
    end else begin
      pre_exp_d_ff          <= pre_exp;
      tot_exp_d_ff          <= tot_exp;
      // A restart drops the fault at once, not one cycle behind the timer
      precond_fault_ff      <= pre_exp && !new_cycle;
      total_expired_ff      <= tot_exp && !new_cycle;
      charge_indicator_n_o  <= 1'b0;
      charge_indicator_n_oe <= is_active(charger_state);
      irq_ff <= temp_irq_pending_ff || temp_irq ||
                (|(nxt_ev_stat & ev_mask_ff));
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Read data only stands in the cycle after the strobe; zero elsewhere.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CHGSUP_REG_CTRL:     reg_rdata_ff <= {4'h0, total_timeout_sel_ff,
                                               precond_timeout_sel_ff};
        `CHGSUP_REG_TEMP:     reg_rdata_ff <= {3'h0, temp_irq_pending_ff, temp_in_range_ff,
                                               temp_master_en_ff, temp_enter_irq_en_ff,
                                               temp_exit_irq_en_ff};
        `CHGSUP_REG_IRQ_STAT: reg_rdata_ff <= {4'h0, ev_stat_ff};
        `CHGSUP_REG_IRQ_MASK: reg_rdata_ff <= {4'h0, ev_mask_ff};
        `CHGSUP_REG_STATE:    reg_rdata_ff <= {3'h0, tot_exp, pre_exp, charger_state};
        default:              reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== pkg/chgsup_consts.vh
/*
  Constants for the charger safety and status logic: register offsets,
  field positions, reset values, the time base and the timeout counts.
  Assumes a 100 MHz core clock.
*/
`ifndef CHGSUP_CONSTS_VH
`define CHGSUP_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define CHGSUP_REG_CTRL      4'h0
`define CHGSUP_REG_TEMP      4'h1
`define CHGSUP_REG_IRQ_STAT  4'h2
`define CHGSUP_REG_IRQ_MASK  4'h3
`define CHGSUP_REG_STATE     4'h4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CHGSUP_CTRL_PRE_LSB   0
`define CHGSUP_CTRL_TOT_LSB   2
`define CHGSUP_TEMP_EXIT_EN   0
`define CHGSUP_TEMP_ENTER_EN  1
`define CHGSUP_TEMP_MASTER_EN 2
`define CHGSUP_TEMP_IN_RANGE  3
`define CHGSUP_TEMP_PENDING   4
`define CHGSUP_EV_EXIT        0
`define CHGSUP_EV_ENTER       1
`define CHGSUP_EV_PRE_TO      2
`define CHGSUP_EV_TOT_TO      3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CHGSUP_CTRL_RST      4'h0
`define CHGSUP_TEMP_EN_RST   3'h0
`define CHGSUP_MASK_RST      4'h0

// ----------------------------------------------------------------------
// Charger states (as reported by the charge state machine)
// ----------------------------------------------------------------------
`define CHGSUP_ST_PRECOND    3'h0
`define CHGSUP_ST_FAST       3'h1
`define CHGSUP_ST_TOPOFF     3'h2
`define CHGSUP_ST_EOC        3'h3
`define CHGSUP_ST_SUSPEND    3'h4
`define CHGSUP_ST_TEMPFLT    3'h5
`define CHGSUP_ST_TIMEFLT    3'h6

// ----------------------------------------------------------------------
// Time base: one tick per second, timeouts counted in seconds
// ----------------------------------------------------------------------
`define CHGSUP_CLK_MHZ       100
`define CHGSUP_TICK_MS       1000
`define CHGSUP_TICK_CYCLES   (`CHGSUP_CLK_MHZ * 1000 * `CHGSUP_TICK_MS)
`define CHGSUP_PRE_MIN_0     40
`define CHGSUP_PRE_MIN_1     60
`define CHGSUP_PRE_MIN_2     80
`define CHGSUP_TOT_HR_0      3
`define CHGSUP_TOT_HR_1      4
`define CHGSUP_TOT_HR_2      5

`endif

// ===== core/chgsup_timer.v
/*
  One charge safety timer: counts time-base ticks, stretched by the
  thermal-regulation current ratio, and flags expiry once per run.
  Assumes a one-cycle tick pulse and a limit of zero meaning disabled.
*/
`timescale 1ns/1ps
`default_nettype none
module chgsup_timer (
  input  wire        mclk,        // Core clock
  input  wire        rst_n,       // Async reset, active low
  input  wire        restart,     // Clear count, new charge cycle
  input  wire        run,         // Timer counts while high
  input  wire        tick,        // One-cycle time base pulse
  input  wire [7:0]  cur_ratio,   // Charge current share, 255 = full
  input  wire [15:0] limit_s,     // Timeout in seconds, 0 = disabled
  output reg         expired_ff   // Timeout reached
);
  reg [15:0] sec_ff;
  reg [7:0]  frac_ff;
  wire [8:0] frac_sum = {1'b0, frac_ff} + {1'b0, cur_ratio} + 9'h001;

  // ----------------------------------------------------------------------
  // Stretched second counter
  // ----------------------------------------------------------------------
  // A second only counts once 256 units of current share piled up, so a
  // halved current doubles the wall-clock period.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sec_ff     <= 16'h0000;
      frac_ff    <= 8'h00;
      expired_ff <= 1'b0;
    end else if (restart) begin
      sec_ff     <= 16'h0000;
      frac_ff    <= 8'h00;
      expired_ff <= 1'b0;
    end else if (run && tick && !expired_ff && limit_s != 16'h0000) begin
      frac_ff <= frac_sum[7:0];
      if (frac_sum[8]) begin
        sec_ff <= sec_ff + 16'h0001;
        if (sec_ff + 16'h0001 >= limit_s)
          expired_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/chgsup_props.sv
/*
  Checker for the charger safety logic, bound to the top module's ports.
  Assumes one clock domain and the register map of the constants header.
*/
`timescale 1ns/1ps
`default_nettype none
module chgsup_props (
  input wire logic       mclk,                  // Core clock
  input wire logic       rst_n,                 // Async reset, active low
  input wire logic [3:0] reg_addr,              // Register index
  input wire logic [7:0] reg_wdata,             // Write data
  input wire logic       reg_wr,                // Write strobe
  input wire logic       reg_rd,                // Read strobe
  input wire logic [7:0] reg_rdata_ff,          // Read data
  input wire logic [2:0] charger_state,         // Charger state
  input wire logic       hot_threshold,         // Not too hot
  input wire logic       cold_threshold,        // Not too cold
  input wire logic       charge_suspend_ff,     // Charging held off
  input wire logic       precond_fault_ff,      // Precondition timeout
  input wire logic       new_cycle,             // New charge cycle
  input wire logic       charge_indicator_n_o,  // Indicator level
  input wire logic       charge_indicator_n_oe, // Indicator sinking
  input wire logic       irq_ff                 // Interrupt
);
  // ----------------------------------------------------------------
  // Helper state: enable shadow, and a settle count after reset
  // ----------------------------------------------------------------
  logic [2:0] temp_en_ff;
  logic [1:0] up_ff;
  wire logic  win = hot_threshold && cold_threshold;

  // Past values are unreliable for three cycles after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp_en_ff <= 3'h0;
      up_ff      <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 4'h1) temp_en_ff <= reg_wdata[2:0];
      if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_leave;   up_ff == 2'h3 && $fell(win); endsequence
  sequence s_enter;   up_ff == 2'h3 && $rose(win); endsequence
  sequence s_temp_rd; up_ff == 2'h3 && reg_rd && reg_addr == 4'h1 && $stable(win); endsequence

  a_suspend_on_exit: assert property (!win |=> charge_suspend_ff)
    else $error("suspend not raised outside window");
  a_suspend_on_return: assert property (win |=> !charge_suspend_ff)
    else $error("suspend held inside window");
  a_indicator_sinks: assert property (charger_state < 3'h3 |=> charge_indicator_n_oe)
    else $error("indicator not sinking while charging");
  a_indicator_floats: assert property (charger_state >= 3'h3 |=> !charge_indicator_n_oe)
    else $error("indicator sinking while idle");
  a_indicator_low: assert property (charge_indicator_n_oe |-> !charge_indicator_n_o)
    else $error("indicator drives high");
  a_exit_irq_raise: assert property ((s_leave ##0 (temp_en_ff[0] && temp_en_ff[2])) |-> ##[1:2] irq_ff)
    else $error("no interrupt on range exit");
  a_enter_irq_raise: assert property ((s_enter ##0 (temp_en_ff[1] && temp_en_ff[2])) |-> ##[1:2] irq_ff)
    else $error("no interrupt on range entry");
  a_range_bit_live: assert property (s_temp_rd |=> reg_rdata_ff[3] == $past(win))
    else $error("range bit does not follow window");
  a_pending_read_clear: assert property (s_temp_rd ##1 s_temp_rd |=> !reg_rdata_ff[4])
    else $error("pending bit survives a read");
  a_pre_fault_hold: assert property (precond_fault_ff && !new_cycle |=> precond_fault_ff)
    else $error("precondition fault dropped");
endmodule
`default_nettype wire

// ===== bench/chgsup_led.sv
/*
  Status lamp with pull-up on the open-drain charge indicator.
  Assumes the design drives the pin only when its enable is high.
*/
`timescale 1ns/1ps
`default_nettype none
module chgsup_led (
  input  wire logic oe,    // Design sinking
  input  wire logic o,     // Design drive level
  output var  logic level  // Resolved pin level
);
  // Released pin is pulled up, so the lamp is dark
  always_comb level = oe ? o : 1'b1;
endmodule
`default_nettype wire

// ===== bench/chgsup_top_tb.sv
/*
  Testbench for the charger safety logic: register tasks, indicator,
  thermistor suspend, interrupts and both safety timers.
  Assumes a timer tick of four clock cycles.
*/
`include "chgsup_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module chgsup_top_tb;
  logic       mclk, rst_n, reg_wr, reg_rd, new_cycle, precond_done;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, ratio, d1, d2;
  logic [2:0] charger_state;
  logic       hot_threshold, cold_threshold, led_level;
  wire  [7:0] reg_rdata_ff;
  wire        suspend, pre_flt, tot_exp, ind_o, ind_oe, irq_ff;
  int         err_count, tests_run, cyc, i;

  chgsup_top #(.TICK_CYCLES(32'd4)) i_chgsup_top (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .charger_state(charger_state), .new_cycle(new_cycle),
    .precond_done(precond_done), .charge_cur_ratio(ratio), .hot_threshold(hot_threshold),
    .cold_threshold(cold_threshold), .charge_suspend_ff(suspend), .precond_fault_ff(pre_flt),
    .total_expired_ff(tot_exp), .charge_indicator_n_o(ind_o),
    .charge_indicator_n_oe(ind_oe), .irq_ff(irq_ff));
  chgsup_led i_chgsup_led (.oe(ind_oe), .o(ind_o), .level(led_level));

  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask
  // Two back-to-back reads of one register
  task automatic rd2(input logic [3:0] a, output logic [7:0] r1, output logic [7:0] r2);
    @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk); #1 r1 = reg_rdata_ff;
    @(posedge mclk); reg_rd <= 1'b0; #1 r2 = reg_rdata_ff;
  endtask
  task automatic set_win(input logic h, input logic c);
    @(posedge mclk); hot_threshold <= h; cold_threshold <= c;
    repeat (3) @(posedge mclk); #1;
  endtask
  task automatic pulse_cycle();
    @(posedge mclk); new_cycle <= 1'b1;
    @(posedge mclk); new_cycle <= 1'b0;
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard: whole run needs about 72700 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin err_count++; summarize(); end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 0; rst_n = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
    charger_state = 0; new_cycle = 0; precond_done = 0; ratio = 8'hFF;
    hot_threshold = 1; cold_threshold = 1; err_count = 0; tests_run = 0; cyc = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    // Lamp lit only in the three charging states
    for (i = 0; i < 7; i++) begin
      @(posedge mclk); charger_state <= i[2:0];
      repeat (2) @(posedge mclk); #1 check({7'h0, led_level}, {7'h0, i >= 3});
    end
    @(posedge mclk); charger_state <= `CHGSUP_ST_PRECOND;
    // Hot then cold excursion with both interrupt enables and master on
    wr(`CHGSUP_REG_TEMP, 8'h07);
    for (i = 0; i < 2; i++) begin
      set_win(i != 0, i == 0);
      check({7'h0, suspend}, 8'h01);
      check({7'h0, irq_ff}, 8'h01);
      rd2(`CHGSUP_REG_TEMP, d1, d2);
      check(d1, 8'h17);
      check(d2, 8'h07);
      check({7'h0, irq_ff}, 8'h00);
      set_win(1'b1, 1'b1);
      check({7'h0, suspend}, 8'h00);
      rd2(`CHGSUP_REG_TEMP, d1, d2);
      check(d1, 8'h1F);
    end
    // Master enable off: no pending, exit reaches irq only via mask
    wr(`CHGSUP_REG_TEMP, 8'h03);
    wr(`CHGSUP_REG_IRQ_MASK, 8'h01);
    set_win(1'b0, 1'b1);
    rd2(`CHGSUP_REG_TEMP, d1, d2);
    check(d1, 8'h03);
    check({7'h0, irq_ff}, 8'h01);
    rd2(`CHGSUP_REG_IRQ_STAT, d1, d2);
    check(d1, 8'h03);
    wr(`CHGSUP_REG_IRQ_STAT, 8'h03);
    set_win(1'b1, 1'b1);
    check({7'h0, irq_ff}, 8'h00);
    rd2(4'h5, d1, d2);
    check(d1, 8'h00);
    rd2(`CHGSUP_REG_TEMP, d1, d2);
    check(d1, 8'h0B);
    // Precondition timeout disabled, then 40 minutes
    wr(`CHGSUP_REG_CTRL, 8'h03);
    pulse_cycle();
    repeat (9700) @(posedge mclk);
    #1 check({7'h0, pre_flt}, 8'h00);
    wr(`CHGSUP_REG_CTRL, 8'h00);
    pulse_cycle();
    repeat (9500) @(posedge mclk);
    #1 check({7'h0, pre_flt}, 8'h00);
    repeat (200) @(posedge mclk);
    #1 check({7'h0, pre_flt}, 8'h01);
    // Total charge timeout of 3 hours from the same restart
    repeat (33300) @(posedge mclk);
    #1 check({7'h0, tot_exp}, 8'h00);
    repeat (400) @(posedge mclk);
    #1 check({7'h0, tot_exp}, 8'h01);
    rd2(`CHGSUP_REG_IRQ_STAT, d1, d2);
    check(d1, 8'h0E);
    // Half current share: the 40 minute precondition period doubles
    @(posedge mclk); ratio <= 8'h7F;
    pulse_cycle();
    repeat (9700) @(posedge mclk);
    #1 check({7'h0, pre_flt}, 8'h00);
    repeat (9800) @(posedge mclk);
    #1 check({7'h0, pre_flt}, 8'h01);
    summarize();
  end
endmodule

bind chgsup_top chgsup_props i_chgsup_props (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .charger_state(charger_state),
  .hot_threshold(hot_threshold), .cold_threshold(cold_threshold),
  .charge_suspend_ff(charge_suspend_ff), .precond_fault_ff(precond_fault_ff),
  .new_cycle(new_cycle), .charge_indicator_n_o(charge_indicator_n_o),
  .charge_indicator_n_oe(charge_indicator_n_oe), .irq_ff(irq_ff));
`default_nettype wire
